// file: pkg/rmpu_regs.svh
// Register indices, field positions and reset values of the region protection unit.
// Assumes system registers are reached by index over the core's register port.
`ifndef RMPU_REGS_SVH
`define RMPU_REGS_SVH

`define RMPU_NUM_REGIONS  8
`define RMPU_IDX_AR0      8'h00
`define RMPU_IDX_PSR0     8'h08
`define RMPU_IDX_GRP_MASK 8'hf8
`define RMPU_IDX_CRA      8'h10
`define RMPU_IDX_CRB      8'h11
`define RMPU_IDX_BRA      8'h12
`define RMPU_IDX_BRB      8'h13
`define RMPU_IDX_APRA     8'h14
`define RMPU_IDX_APRB     8'h15
`define RMPU_IDX_CR       8'h16

`define RMPU_AR_VALID_BIT 0
`define RMPU_AR_SIZE_LSB  1
`define RMPU_AR_SIZE_MSB  5
`define RMPU_AR_BASE_LSB  12
`define RMPU_AR_WMASK     32'hffff_f03f
`define RMPU_PSR_WMASK    32'h0000_ffff
`define RMPU_CR_EN_BIT    0

`define RMPU_SIZE_MIN     5'h0b
`define RMPU_SUB_SHIFT    5'h03
`define RMPU_RST_WORD     32'h0000_0000
`define RMPU_RST_EN       1'b0

`endif

// file: pkg/rmpu_pkg.sv
// Types shared by the region protection unit and its permission decoder.
// Assumes nothing of its surroundings.
package rmpu_pkg;

	typedef enum logic [1:0] {
		acc_fetch,
		acc_read,
		acc_write
	} acc_type_t;

	typedef enum logic [2:0] {
		flt_none,
		flt_fetch_perm,
		flt_data_perm,
		flt_fetch_miss,
		flt_data_miss,
		flt_multi_hit
	} fault_t;

endpackage

// file: rtl/permission_decode.sv
// Decodes a four-bit region permission field into read, write and execute rights.
// Assumes the privilege mode input is high for privileged accesses.
`timescale 1ns/100ps

module permission_decode (
	input  wire logic [3:0] code_i,
	input  wire logic       priv_i,
	output logic            rd_o,
	output logic            wr_o,
	output logic            ex_o
);
	import rmpu_pkg::*;

	// Rights are packed as {read, write, execute}
	logic [2:0] priv_rights;
	logic [2:0] user_rights;

	always_comb begin
		priv_rights = 3'h0;
		user_rights = 3'h0;
		unique case (code_i)
			4'h0: priv_rights = 3'h4;
			4'h1: priv_rights = 3'h5;
			4'h2: priv_rights = 3'h6;
			4'h3: priv_rights = 3'h7;
			4'h4: begin
				priv_rights = 3'h4;
				user_rights = 3'h4;
			end
			4'h5: begin
				priv_rights = 3'h5;
				user_rights = 3'h5;
			end
			4'h6: begin
				priv_rights = 3'h6;
				user_rights = 3'h6;
			end
			4'h7: begin
				priv_rights = 3'h7;
				user_rights = 3'h7;
			end
			4'h8: begin
				priv_rights = 3'h6;
				user_rights = 3'h4;
			end
			4'h9: begin
				priv_rights = 3'h6;
				user_rights = 3'h5;
			end
			4'ha: begin
				priv_rights = 3'h0;
				user_rights = 3'h0;
			end
			default: begin
				priv_rights = 3'h0;
				user_rights = 3'h0;
			end
		endcase
	end

	wire [2:0] rights = priv_i ? priv_rights : user_rights;

	assign rd_o = rights[2];
	assign wr_o = rights[1];
	assign ex_o = rights[0];

endmodule

// file: rtl/region_memory_protection_unit.sv
// Region-based memory protection checker for fetch and data accesses of the core.
// Assumes the core presents one access per cycle at most and drives the system
// register port on the same clock; all inputs are synchronous to clk_i.
//
// Overview of operation
// - Cacheable registers hold one bit per region, cleared at reset.
// - Bufferable registers hold one bit per region, cleared at reset.
// - Cacheable and bufferable register pairs may be left out without caches.
// - Both permission registers reset to zero: privileged read, unprivileged none.
// - Codes 0 to 3 give privileged-only rights, read up to read/write/execute.
// - Codes 4 to 7 give the same rights in both modes.
// - Code 8: privileged read/write, user read; code 9 adds user execute.
// - Code 10 grants nothing; codes 11 to 15 must not be programmed.
// - Checking happens only while enable is set; otherwise no exception.
// - Fetch without execute right raises fetch permission fault, records address.
// - Data access without right raises data permission fault, records address.
// - Fetch outside every valid region raises fetch miss fault, records address.
// - Data access outside every valid region raises data miss fault.
// - Access hitting several valid regions raises multiple hit fault.
// - Each region splits into sixteen equal ascending subregions from its base.
// - Each permission register holds one four-bit field per region, indexed by region.
// - Select bit n of a region picks register B for subregion n, else A.
// - While disabled, accesses are uncacheable, unbufferable and never fault.
// - Select value 0 chooses the first register field, 1 the second.
// - Address register holds base bits 31:12 and size code 11 to 31.
// - Only regions with valid bit set are matched; valid clears at reset.
`timescale 1ns/100ps
`include "rmpu_regs.svh"

module region_memory_protection_unit #(
	parameter bit HAS_CACHE_ATTR = 1'b1
) (
	input  wire logic                clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                sr_wen_i,
	input  wire logic                sr_ren_i,
	input  wire logic [7:0]          sr_idx_i,
	input  wire logic [31:0]         sr_wdata_i,
	output logic      [31:0]         sr_rdata_o,
	input  wire logic                acc_req_i,
	input  wire rmpu_pkg::acc_type_t acc_type_i,
	input  wire logic                acc_priv_i,
	input  wire logic [31:0]         acc_addr_i,
	input  wire logic [31:0]         acc_pc_i,
	output logic                     rsp_valid_o,
	output logic                     rsp_permit_o,
	output rmpu_pkg::fault_t         rsp_fault_o,
	output logic                     rsp_cacheable_o,
	output logic                     rsp_bufferable_o,
	output logic      [31:0]         fault_pc_o
);
	import rmpu_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [31:0] ar_q  [`RMPU_NUM_REGIONS];
	logic [15:0] psr_q [`RMPU_NUM_REGIONS];
	logic [7:0]  cra_q;
	logic [7:0]  crb_q;
	logic [7:0]  bra_q;
	logic [7:0]  brb_q;
	logic [31:0] apra_q;
	logic [31:0] aprb_q;
	logic        en_q;

	wire ar_grp  = (sr_idx_i & `RMPU_IDX_GRP_MASK) == `RMPU_IDX_AR0;
	wire psr_grp = (sr_idx_i & `RMPU_IDX_GRP_MASK) == `RMPU_IDX_PSR0;
	wire cra_we  = HAS_CACHE_ATTR && sr_wen_i && sr_idx_i == `RMPU_IDX_CRA;
	wire crb_we  = HAS_CACHE_ATTR && sr_wen_i && sr_idx_i == `RMPU_IDX_CRB;
	wire bra_we  = HAS_CACHE_ATTR && sr_wen_i && sr_idx_i == `RMPU_IDX_BRA;
	wire brb_we  = HAS_CACHE_ATTR && sr_wen_i && sr_idx_i == `RMPU_IDX_BRB;
	wire apra_we = sr_wen_i && sr_idx_i == `RMPU_IDX_APRA;
	wire aprb_we = sr_wen_i && sr_idx_i == `RMPU_IDX_APRB;
	wire cr_we   = sr_wen_i && sr_idx_i == `RMPU_IDX_CR;

	// Without caches the attribute registers never load and read as zero
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cra_q <= 8'h00;
			crb_q <= 8'h00;
			bra_q <= 8'h00;
			brb_q <= 8'h00;
		end else begin
			if (cra_we) cra_q <= sr_wdata_i[7:0];
			if (crb_we) crb_q <= sr_wdata_i[7:0];
			if (bra_we) bra_q <= sr_wdata_i[7:0];
			if (brb_we) brb_q <= sr_wdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			apra_q <= `RMPU_RST_WORD;
			aprb_q <= `RMPU_RST_WORD;
			en_q   <= `RMPU_RST_EN;
		end else begin
			if (apra_we) apra_q <= sr_wdata_i;
			if (aprb_we) aprb_q <= sr_wdata_i;
			if (cr_we) en_q <= sr_wdata_i[`RMPU_CR_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-region address match and subregion selection

	logic [7:0] hit;
	logic [7:0] sel_b;
	logic [3:0] code_w [`RMPU_NUM_REGIONS];
	logic [7:0] cach_w;
	logic [7:0] buf_w;

	for (genvar g = 0; g < `RMPU_NUM_REGIONS; g++) begin : g_region
		wire        ar_we  = sr_wen_i && ar_grp && sr_idx_i[2:0] == 3'(g);
		wire        psr_we = sr_wen_i && psr_grp && sr_idx_i[2:0] == 3'(g);
		wire        valid  = ar_q[g][`RMPU_AR_VALID_BIT];
		wire [4:0]  size   = ar_q[g][`RMPU_AR_SIZE_MSB:`RMPU_AR_SIZE_LSB];
		wire [19:0] base   = ar_q[g][31:`RMPU_AR_BASE_LSB];
		wire [19:0] cmp_mask;
		wire [3:0]  sub_idx;

		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				ar_q[g]  <= `RMPU_RST_WORD;
				psr_q[g] <= 16'h0000;
			end else begin
				if (ar_we) ar_q[g] <= sr_wdata_i & `RMPU_AR_WMASK;
				if (psr_we) psr_q[g] <= sr_wdata_i[15:0];
			end
		end

		// Address bit j+12 takes part in the match only above the region size
		for (genvar j = 0; j < 20; j++) begin : g_mask
			assign cmp_mask[j] = 5'(j + 12) > size;
		end

		// Undefined size codes never match
		assign hit[g] = valid && size >= `RMPU_SIZE_MIN
			&& ((acc_addr_i[31:12] ^ base) & cmp_mask) == 20'h00000;

		// Subregion is the four address bits just below the region size
		assign sub_idx  = 4'(acc_addr_i >> (size - `RMPU_SUB_SHIFT));
		assign sel_b[g] = psr_q[g][sub_idx];
		assign code_w[g] = sel_b[g] ? aprb_q[4*g +: 4] : apra_q[4*g +: 4];
		assign cach_w[g] = sel_b[g] ? crb_q[g] : cra_q[g];
		assign buf_w[g]  = sel_b[g] ? brb_q[g] : bra_q[g];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Hit resolution and permission check

	logic [2:0] hit_idx;

	// Lowest hitting region wins; several hits are faulted anyway
	always_comb begin
		hit_idx = 3'h0;
		for (int k = `RMPU_NUM_REGIONS - 1; k >= 0; k--) begin
			if (hit[k]) hit_idx = 3'(k);
		end
	end

	wire       any_hit   = |hit;
	wire       multi_hit = (hit & (hit - 8'h01)) != 8'h00;
	wire [3:0] sel_code  = code_w[hit_idx];
	wire       is_fetch  = acc_type_i == acc_fetch;
	wire       can_rd;
	wire       can_wr;
	wire       can_ex;

	permission_decode u_decode (
		.code_i (sel_code),
		.priv_i (acc_priv_i),
		.rd_o   (can_rd),
		.wr_o   (can_wr),
		.ex_o   (can_ex)
	);

	wire need_ok = is_fetch ? can_ex : (acc_type_i == acc_read) ? can_rd : can_wr;

	fault_t fault_d;
	assign fault_d = !en_q ? flt_none :
		multi_hit ? flt_multi_hit :
		!any_hit ? (is_fetch ? flt_fetch_miss : flt_data_miss) :
		!need_ok ? (is_fetch ? flt_fetch_perm : flt_data_perm) :
		flt_none;

	wire attr_ok = en_q && any_hit && !multi_hit;
	wire cach_d  = attr_ok && cach_w[hit_idx];
	wire buf_d   = attr_ok && buf_w[hit_idx];

	////////////////////////////////////////////////////////////////////////////////
	// Response registers

	logic   rsp_valid_q;
	logic   permit_q;
	fault_t fault_q;
	logic   cach_q;
	logic   buf_q;
	logic [31:0] pc_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_valid_q <= 1'b0;
			permit_q    <= 1'b0;
			fault_q     <= flt_none;
			cach_q      <= 1'b0;
			buf_q       <= 1'b0;
		end else begin
			rsp_valid_q <= acc_req_i;
			if (acc_req_i) begin
				permit_q <= fault_d == flt_none;
				fault_q  <= fault_d;
				cach_q   <= cach_d;
				buf_q    <= buf_d;
			end
		end
	end

	// Address of the failing instruction, for the exception stack frame
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_q <= `RMPU_RST_WORD;
		end else if (acc_req_i && fault_d != flt_none) begin
			pc_q <= acc_pc_i;
		end
	end

	assign rsp_valid_o      = rsp_valid_q;
	assign rsp_permit_o     = permit_q;
	assign rsp_fault_o      = fault_q;
	assign rsp_cacheable_o  = cach_q;
	assign rsp_bufferable_o = buf_q;
	assign fault_pc_o       = pc_q;

	////////////////////////////////////////////////////////////////////////////////
	// Register read port

	logic [31:0] rd_word;
	logic [31:0] rdata_q;

	always_comb begin
		rd_word = 32'h0000_0000;
		if (ar_grp) rd_word = ar_q[sr_idx_i[2:0]];
		else if (psr_grp) rd_word = {16'h0000, psr_q[sr_idx_i[2:0]]};
		else if (sr_idx_i == `RMPU_IDX_CRA) rd_word = {24'h000000, cra_q};
		else if (sr_idx_i == `RMPU_IDX_CRB) rd_word = {24'h000000, crb_q};
		else if (sr_idx_i == `RMPU_IDX_BRA) rd_word = {24'h000000, bra_q};
		else if (sr_idx_i == `RMPU_IDX_BRB) rd_word = {24'h000000, brb_q};
		else if (sr_idx_i == `RMPU_IDX_APRA) rd_word = apra_q;
		else if (sr_idx_i == `RMPU_IDX_APRB) rd_word = aprb_q;
		else if (sr_idx_i == `RMPU_IDX_CR) rd_word = {31'h0000_0000, en_q};
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= `RMPU_RST_WORD;
		end else if (sr_ren_i) begin
			rdata_q <= rd_word;
		end
	end

	assign sr_rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_rsp_one_cycle: assert property (
		acc_req_i |=> rsp_valid_o
	) else $error("response did not follow request by one cycle");

	chk_disabled_clean: assert property (
		acc_req_i && !en_q |=> rsp_fault_o == flt_none && rsp_permit_o
	) else $error("fault raised while checking disabled");

	chk_disabled_attr: assert property (
		acc_req_i && !en_q |=> !rsp_cacheable_o && !rsp_bufferable_o
	) else $error("attributes set while checking disabled");

	chk_fetch_miss: assert property (
		acc_req_i && en_q && hit == 8'h00 && is_fetch
		|=> rsp_fault_o == flt_fetch_miss && fault_pc_o == $past(acc_pc_i)
	) else $error("fetch outside regions not reported as miss");

	chk_data_miss: assert property (
		acc_req_i && en_q && hit == 8'h00 && !is_fetch
		|=> rsp_fault_o == flt_data_miss && !rsp_permit_o
	) else $error("data access outside regions not reported as miss");

	chk_multi_hit: assert property (
		acc_req_i && en_q && $countones(hit) > 1 |=> rsp_fault_o == flt_multi_hit
	) else $error("multiple region hit not reported");

	chk_fetch_exec: assert property (
		acc_req_i && en_q && $onehot(hit) && is_fetch && !can_ex
		|=> rsp_fault_o == flt_fetch_perm && fault_pc_o == $past(acc_pc_i)
	) else $error("fetch without execute right not faulted");

	chk_write_right: assert property (
		acc_req_i && en_q && $onehot(hit) && acc_type_i == acc_write
		|=> rsp_permit_o == $past(can_wr)
	) else $error("write permit does not follow write right");

	chk_code_none: assert property (
		sel_code >= 4'ha |-> !can_rd && !can_wr && !can_ex
	) else $error("no-access or undefined code grants rights");

	chk_reset_code: assert property (
		sel_code == 4'h0 |-> can_rd == acc_priv_i && !can_wr && !can_ex
	) else $error("code zero rights wrong");

	chk_apr_load: assert property (
		apra_we |=> apra_q == $past(sr_wdata_i)
	) else $error("permission register did not load");

	chk_cache_absent: assert property (
		!HAS_CACHE_ATTR |-> cra_q == 8'h00 && crb_q == 8'h00 && !rsp_cacheable_o
	) else $error("cache attribute present in cacheless build");

	chk_rsp_idle: assert property (
		!acc_req_i |=> !rsp_valid_o
	) else $error("response without request");

	chk_read_right: assert property (
		acc_req_i && en_q && $onehot(hit) && acc_type_i == acc_read
		|=> rsp_permit_o == $past(can_rd)
	) else $error("read permit does not follow read right");

	chk_data_perm: assert property (
		acc_req_i && en_q && $onehot(hit) && !is_fetch && !need_ok
		|=> rsp_fault_o == flt_data_perm && fault_pc_o == $past(acc_pc_i)
	) else $error("data access without right not faulted");

	chk_multi_attr: assert property (
		acc_req_i && en_q && $countones(hit) > 1
		|=> !rsp_cacheable_o && !rsp_bufferable_o
	) else $error("attributes set on multiple region hit");

	chk_pc_hold: assert property (
		acc_req_i && en_q && $onehot(hit) && need_ok
		|=> $stable(fault_pc_o)
	) else $error("fault address changed without a fault");

	chk_enable_load: assert property (
		cr_we |=> en_q == $past(sr_wdata_i[`RMPU_CR_EN_BIT])
	) else $error("enable bit did not load");

endmodule

// file: testbench/core_model.sv
// Core-side partner: fetch and load/store stages driving the register and access ports.
// Assumes the unit samples on the rising edge; this side changes signals at the falling edge.
`timescale 1ns/100ps

module core_model (
	input  wire logic          clk_i,
	input  wire logic [31:0]   sr_rdata_i,
	output logic               sr_wen_o,
	output logic               sr_ren_o,
	output logic [7:0]         sr_idx_o,
	output logic [31:0]        sr_wdata_o,
	output logic               acc_req_o,
	output rmpu_pkg::acc_type_t acc_type_o,
	output logic               acc_priv_o,
	output logic [31:0]        acc_addr_o,
	output logic [31:0]        acc_pc_o
);
	import rmpu_pkg::*;

	initial begin
		{sr_wen_o, sr_ren_o, acc_req_o, acc_priv_o} = '0;
		{sr_idx_o, sr_wdata_o, acc_addr_o, acc_pc_o} = '0;
		acc_type_o = acc_fetch;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Released lines show the inverse, so a stale value can never pass
	task automatic reg_wr(input logic [7:0] idx, input logic [31:0] d);
		@(negedge clk_i);
		sr_wen_o = 1'b1;
		sr_idx_o = idx;
		sr_wdata_o = d;
		@(negedge clk_i);
		sr_wen_o = 1'b0;
		sr_wdata_o = ~d;
	endtask

	task automatic reg_rd(input logic [7:0] idx, output logic [31:0] d);
		@(negedge clk_i);
		sr_ren_o = 1'b1;
		sr_idx_o = idx;
		@(negedge clk_i);
		sr_ren_o = 1'b0;
		sr_idx_o = ~idx;
		d = sr_rdata_i;
	endtask

	task automatic access(input acc_type_t t, input logic p, input logic [31:0] a,
		input logic [31:0] pc);
		@(negedge clk_i);
		acc_req_o = 1'b1;
		acc_type_o = t;
		acc_priv_o = p;
		acc_addr_o = a;
		acc_pc_o = pc;
	endtask

	task automatic idle();
		@(negedge clk_i);
		acc_req_o = 1'b0;
		acc_addr_o = ~acc_addr_o;
		acc_pc_o = ~acc_pc_o;
	endtask
endmodule

// file: testbench/tb.sv
// Self-checking bench: random regions and accesses compared with a behavioural model.
// Assumes the core partner drives all unit inputs but clock and reset at the falling clock edge.
`timescale 1ns/100ps

module tb;
	import rmpu_pkg::*;
	typedef struct packed {logic [5:0] r; logic [31:0] pc;} exp_t;
	logic              clk_i, rst_n_i, sr_wen_i, sr_ren_i, acc_req_i, acc_priv_i;
	logic [7:0]        sr_idx_i;
	logic [31:0]       sr_wdata_i, sr_rdata_o, acc_addr_i, acc_pc_i, fault_pc_o, m_fpc;
	acc_type_t         acc_type_i;
	fault_t            rsp_fault_o;
	logic              rsp_valid_o, rsp_permit_o, rsp_cacheable_o, rsp_bufferable_o, exp_v;
	logic              nc_permit, nc_cach, nc_buf;
	fault_t            nc_fault;
	logic [31:0]       mreg [0:255];
	int                miscompares, n_checks;
	exp_t              q[$];

	always #10 clk_i = ~clk_i;

	core_model core (.clk_i(clk_i), .sr_rdata_i(sr_rdata_o), .sr_wen_o(sr_wen_i),
		.sr_ren_o(sr_ren_i), .sr_idx_o(sr_idx_i), .sr_wdata_o(sr_wdata_i),
		.acc_req_o(acc_req_i), .acc_type_o(acc_type_i), .acc_priv_o(acc_priv_i),
		.acc_addr_o(acc_addr_i), .acc_pc_o(acc_pc_i));

	region_memory_protection_unit DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sr_wen_i(sr_wen_i),
		.sr_ren_i(sr_ren_i), .sr_idx_i(sr_idx_i), .sr_wdata_i(sr_wdata_i),
		.sr_rdata_o(sr_rdata_o), .acc_req_i(acc_req_i), .acc_type_i(acc_type_i),
		.acc_priv_i(acc_priv_i), .acc_addr_i(acc_addr_i), .acc_pc_i(acc_pc_i),
		.rsp_valid_o(rsp_valid_o), .rsp_permit_o(rsp_permit_o), .rsp_fault_o(rsp_fault_o),
		.rsp_cacheable_o(rsp_cacheable_o), .rsp_bufferable_o(rsp_bufferable_o),
		.fault_pc_o(fault_pc_o));

	// Cacheless build on the same ports: attributes must stay clear
	region_memory_protection_unit #(.HAS_CACHE_ATTR(1'b0)) nocache_dut (.clk_i(clk_i),
		.rst_n_i(rst_n_i), .sr_wen_i(sr_wen_i), .sr_ren_i(sr_ren_i), .sr_idx_i(sr_idx_i),
		.sr_wdata_i(sr_wdata_i), .sr_rdata_o(), .acc_req_i(acc_req_i),
		.acc_type_i(acc_type_i), .acc_priv_i(acc_priv_i), .acc_addr_i(acc_addr_i),
		.acc_pc_i(acc_pc_i), .rsp_valid_o(), .rsp_permit_o(nc_permit),
		.rsp_fault_o(nc_fault), .rsp_cacheable_o(nc_cach), .rsp_bufferable_o(nc_buf),
		.fault_pc_o());

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [31:0] wmask(int i);
		if (i < 8) return 32'hffff_f03f;
		if (i < 16) return 32'h0000_ffff;
		if (i < 20) return 32'h0000_00ff;
		if (i < 22) return 32'hffff_ffff;
		if (i == 22) return 32'h0000_0001;
		return 32'h0;
	endfunction

	// Returns permit, fault kind, cacheable, bufferable
	function automatic logic [5:0] model(int t, bit p, logic [31:0] a);
		int hits, hn, sh, sub;
		logic [3:0] c;
		logic [2:0] rwx;
		bit s, ok;
		hits = 0;
		hn = 0;
		for (int n = 0; n < 8; n++) begin
			sh = mreg[n][5:1] + 1;
			if (mreg[n][0] && sh > 11 &&
				({32'h0, a} >> sh) == ({32'h0, mreg[n] & 32'hffff_f000} >> sh)) begin
				hits++;
				hn = n;
			end
		end
		if (!mreg[22][0]) return {1'b1, flt_none, 2'b00};
		if (hits > 1) return {1'b0, flt_multi_hit, 2'b00};
		if (hits == 0) return {1'b0, (t == 0) ? flt_fetch_miss : flt_data_miss, 2'b00};
		sh = mreg[hn][5:1] - 3;
		sub = (a >> sh) & 15;
		s = mreg[8 + hn][sub];
		c = s ? mreg[21][4 * hn +: 4] : mreg[20][4 * hn +: 4];
		case (c)
			4'h0, 4'h1, 4'h2, 4'h3: rwx = p ? {1'b1, c[1], c[0]} : 3'b000;
			4'h4, 4'h5, 4'h6, 4'h7: rwx = {1'b1, c[1], c[0]};
			4'h8: rwx = p ? 3'b110 : 3'b100;
			4'h9: rwx = p ? 3'b110 : 3'b101;
			default: rwx = 3'b000;
		endcase
		ok = (t == 0) ? rwx[0] : (t == 1) ? rwx[2] : rwx[1];
		return {ok, ok ? flt_none : ((t == 0) ? flt_fetch_perm : flt_data_perm),
			s ? mreg[17][hn] : mreg[16][hn], s ? mreg[19][hn] : mreg[18][hn]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(int i, logic [31:0] d);
		core.reg_wr(i[7:0], d);
		mreg[i[7:0]] = d & wmask(i);
	endtask

	task automatic rd_chk(int i);
		logic [31:0] d;
		core.reg_rd(i[7:0], d);
		check("sr_rdata", d, mreg[i[7:0]]);
	endtask

	task automatic acc(int t, bit p, logic [31:0] a, logic [31:0] pc);
		exp_t e;
		e.r = model(t, p, a);
		if (!e.r[5]) m_fpc = pc;
		e.pc = m_fpc;
		q.push_back(e);
		core.access(acc_type_t'(t), p, a, pc);
	endtask

	task automatic do_reset();
		@(negedge clk_i);
		rst_n_i = 1'b0;
		repeat (16) @(negedge clk_i);
		foreach (mreg[k]) mreg[k] = '0;
		m_fpc = '0;
		rst_n_i = 1'b1;
		for (int i = 0; i < 24; i++) rd_chk(i);
	endtask

	task automatic cfg_regions(int it);
		int sz, u;
		logic [63:0] lo;
		for (int n = 0; n < 8; n++) begin
			sz = 8 + $urandom % 24;
			lo = (64'h1 << (sz + 1)) - 1;
			wr(n, ($urandom & ~lo[31:0] & 32'hffff_f000) | ($urandom & 32'hfc0) | (sz << 1)
				| ($urandom % 4 != 0));
			wr(8 + n, $urandom);
		end
		for (int i = 16; i < 20; i++) wr(i, $urandom);
		wr(20, (it < 16) ? {8{it[3:0]}} : $urandom);
		wr(21, $urandom);
		wr(22, ($urandom & 32'hffff_fffe) | ($urandom % 4 != 0));
		u = 23 + $urandom % 233;
		wr(u, $urandom);
		rd_chk(u);
		for (int i = 0; i < 23; i++) rd_chk(i);
	endtask

	task automatic rand_acc();
		int n, sz;
		logic [63:0] lo;
		logic [31:0] a;
		n = $urandom % 8;
		sz = mreg[n][5:1];
		lo = (64'h1 << (sz + 1)) - 1;
		a = (mreg[n] & 32'hffff_f000 & ~lo[31:0]) | ($urandom & lo[31:0]);
		if ($urandom % 5 == 0) a = $urandom;
		acc($urandom % 3, $urandom % 2, a, $urandom);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) exp_v <= 1'b0;
		else exp_v <= acc_req_i;
	end

	always @(negedge clk_i) begin
		exp_t e;
		if (rst_n_i) begin
			check("rsp_valid", rsp_valid_o, exp_v);
			if (exp_v) begin
				e = q.pop_front();
				check("permit", rsp_permit_o, e.r[5]);
				check("fault", rsp_fault_o, e.r[4:2]);
				check("fault_pc", fault_pc_o, e.pc);
				check("attr", {rsp_cacheable_o, rsp_bufferable_o}, e.r[1:0]);
				check("nc_permit", nc_permit, e.r[5]);
				check("nc_fault", nc_fault, e.r[4:2]);
				check("nc_attr", {nc_cach, nc_buf}, 2'b00);
			end
		end
	end

	initial begin
		#400_000;
		miscompares++;
		finish_test();
	end

	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		miscompares = 0;
		n_checks = 0;
		void'($urandom(65646));
		do_reset();
		for (int it = 0; it < 24; it++) begin
			cfg_regions(it);
			repeat (40) rand_acc();
			core.idle();
		end
		do_reset();
		cfg_regions(0);
		repeat (20) rand_acc();
		core.idle();
		core.idle();
		finish_test();
	end
endmodule
